// *** inc/smr_regs.svh ***
`ifndef SMR_REGS_SVH
`define SMR_REGS_SVH

// Register indices; the byte address is four times the index
`define SMR_IDX_SUPPLY   3'h1
`define SMR_IDX_MONITOR  3'h2
`define SMR_IDX_STATUS   3'h3
`define SMR_IDX_REVPART  3'h5
// Index field inside a byte address
`define SMR_IDX_LSB      2
`define SMR_IDX_W        3
// Reset values
`define SMR_SUPPLY_RST   8'h74
`define SMR_MONITOR_RST  8'h60
`define SMR_STATUS_RST   8'h00
// Writable bits; reserved bits stay zero
`define SMR_SUPPLY_WMASK  8'h7f
`define SMR_MONITOR_WMASK 8'h7e
// AXI responses
`define SMR_RESP_OKAY    2'h0
`define SMR_RESP_SLVERR  2'h2
// Analog output select code meaning off
`define SMR_AOUT_OFF     3'h0

`endif

// *** inc/smr_pkg.sv ***
package smr_pkg;

    // Supply control word
    typedef struct packed {
        logic       rsvd7;              // Reserved, reads zero
        logic       ldo20_enable;       // 20 V regulator on
        logic       conv2_enable;       // Second converter on
        logic       clock_out_enable;   // External clock out on
        logic       tx_monitor_enable;  // Trigger pin driven
        logic [2:0] ldo20_current_trim; // Current limit trim
    } smr_supply_t;

    // Monitor control word
    typedef struct packed {
        logic       rsvd7;               // Reserved, reads zero
        logic       ldo20_monitor_mask;  // 1 excludes 20 V rail
        logic       conv2_monitor_mask;  // 1 excludes conv2 rail
        logic       filter_monitor_mask; // 1 excludes filter rail
        logic [2:0] analog_out_select;   // Analog output source
        logic       rsvd0;               // Reserved, reads zero
    } smr_monitor_t;

    // Status word, also the analog status input bundle
    typedef struct packed {
        logic rsvd7;                 // Reserved, reads zero
        logic ldo20_rail;            // 20 V rail above threshold
        logic conv2_rail;            // Conv2 rail above threshold
        logic bus_voltage_good;      // Bus above threshold
        logic filter_rail;           // Filter rail above threshold
        logic xtal_running;          // Crystal running
        logic thermal_warning;       // Thermal warning now
        logic thermal_shutdown_seen; // Earlier thermal shutdown
    } smr_status_t;

    // Analog output sources
    typedef enum logic [2:0] {
        SMR_AOUT_DISABLED = 3'h0,
        SMR_AOUT_BUS_IN   = 3'h1,
        SMR_AOUT_FILTER   = 3'h2,
        SMR_AOUT_LDO20    = 3'h3,
        SMR_AOUT_CONV2    = 3'h4,
        SMR_AOUT_ANALOG   = 3'h5,
        SMR_AOUT_BUS_CUR  = 3'h6,
        SMR_AOUT_TEMP     = 3'h7
    } smr_aout_t;

endpackage : smr_pkg

// *** hdl/smr_top.sv ***
`timescale 1ns/1ps
`include "smr_regs.svh"
module smr_top
    import smr_pkg::*;
#(
    parameter int        ADDR_W   = 8,     // AXI address width
    parameter logic [2:0] REVISION = 3'h1, // Arbitrary value
    parameter logic [4:0] PART_NUM = 5'h12 // Arbitrary value
) (
    input  logic              aclk,
    input  logic              aresetn,
    input  logic [ADDR_W-1:0] s_axi_awaddr,
    input  logic              s_axi_awvalid,
    output logic              s_axi_awready,
    input  logic [31:0]       s_axi_wdata,
    input  logic [3:0]        s_axi_wstrb,
    input  logic              s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  logic              s_axi_bready,
    input  logic [ADDR_W-1:0] s_axi_araddr,
    input  logic              s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  logic              s_axi_rready,
    input  smr_status_t       analog_status,
    input  logic              tx_activity,
    input  logic              clock_src,
    output logic              ldo20_on,
    output logic              conv2_on,
    output logic              clock_out_pin,
    output logic              tx_monitor_pin_o,
    output logic              tx_monitor_pin_oe,
    output logic [2:0]        ldo20_current_trim,
    output logic [2:0]        analog_out_select,
    output logic              analog_out_on,
    output logic              power_fail_warning_n
);

    localparam int IW = `SMR_IDX_W; // Index width
    localparam int NMON = 3;        // Masked monitors

    // Refuse an address bus too narrow for the map
    if (ADDR_W < `SMR_IDX_LSB + `SMR_IDX_W) begin : g_chk
        $error("smr_top: ADDR_W too small");
    end

    // Register map decode, shared by both paths
    function automatic logic smr_mapped(input logic [IW-1:0] idx);
        smr_mapped = (idx == `SMR_IDX_SUPPLY) ||
                     (idx == `SMR_IDX_MONITOR) ||
                     (idx == `SMR_IDX_STATUS) ||
                     (idx == `SMR_IDX_REVPART);
    endfunction : smr_mapped

    // Storage
    smr_supply_t   supply_ff;    // Supply control
    smr_monitor_t  monitor_ff;   // Monitor control
    smr_status_t   status_ff;    // Sampled status
    logic          aw_got_ff;    // Write address held
    logic          w_got_ff;     // Write data held
    logic [IW-1:0] waddr_ff;     // Held write index
    logic [7:0]    wdata_ff;     // Held low data byte
    logic          wstrb_ff;     // Held low lane strobe
    logic          awready_ff;
    logic          wready_ff;
    logic          bvalid_ff;
    logic [1:0]    bresp_ff;
    logic          arready_ff;
    logic          rvalid_ff;
    logic [1:0]    rresp_ff;
    logic [7:0]    rdata_ff;     // Low byte; upper bits zero
    logic          ldo20_on_ff;
    logic          conv2_on_ff;
    logic          clk_out_ff;
    logic          trig_o_ff;
    logic          trig_oe_ff;
    logic [2:0]    trim_ff;
    logic [2:0]    aout_sel_ff;
    logic          aout_on_ff;
    logic          warn_n_ff;

    // Combinational helpers
    logic          aw_hs;        // Write address handshake
    logic          w_hs;         // Write data handshake
    logic          ar_hs;        // Read address handshake
    logic          wr_fire;      // Write carried out
    logic [IW-1:0] raddr;        // Read index
    logic [7:0]    nxt_rdata;    // Read mux result
    logic [NMON-1:0] mon_ok;     // Monitor states
    logic [NMON-1:0] mon_mask;   // Monitor masks
    logic [NMON-1:0] mon_pass;   // Ok or excluded

    assign aw_hs   = s_axi_awvalid & awready_ff;
    assign w_hs    = s_axi_wvalid & wready_ff;
    assign ar_hs   = s_axi_arvalid & arready_ff;
    assign wr_fire = aw_got_ff & w_got_ff & ~bvalid_ff;
    assign raddr   = s_axi_araddr[`SMR_IDX_LSB +: IW];

    // Write address capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff  <= 1'b0;
            waddr_ff   <= '0;
            awready_ff <= 1'b0;
        end else if (aw_hs) begin
            aw_got_ff  <= 1'b1;
            waddr_ff   <= s_axi_awaddr[`SMR_IDX_LSB +: IW];
            awready_ff <= 1'b0;
        end else if (wr_fire) begin
            aw_got_ff  <= 1'b0;
        end else if (!aw_got_ff && !bvalid_ff) begin
            awready_ff <= 1'b1;
        end
    end

    // Write data capture, low byte lane only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_got_ff  <= 1'b0;
            wdata_ff  <= '0;
            wstrb_ff  <= 1'b0;
            wready_ff <= 1'b0;
        end else if (w_hs) begin
            w_got_ff  <= 1'b1;
            wdata_ff  <= s_axi_wdata[7:0];
            wstrb_ff  <= s_axi_wstrb[0];
            wready_ff <= 1'b0;
        end else if (wr_fire) begin
            w_got_ff  <= 1'b0;
        end else if (!w_got_ff && !bvalid_ff) begin
            wready_ff <= 1'b1;
        end
    end

    // Write response; unmapped index answers SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= `SMR_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= smr_mapped(waddr_ff) ? `SMR_RESP_OKAY
                                              : `SMR_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Supply control register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            supply_ff <= `SMR_SUPPLY_RST;
        end else if (wr_fire && wstrb_ff &&
                     waddr_ff == `SMR_IDX_SUPPLY) begin
            supply_ff <= wdata_ff & `SMR_SUPPLY_WMASK;
        end
    end

    // Monitor control register, bits 0 and 7 held at zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            monitor_ff <= `SMR_MONITOR_RST;
        end else if (wr_fire && wstrb_ff &&
                     waddr_ff == `SMR_IDX_MONITOR) begin
            monitor_ff <= wdata_ff & `SMR_MONITOR_WMASK;
        end
    end

    // Status sampling; bus writes never reach it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_ff <= `SMR_STATUS_RST;
        end else begin
            status_ff       <= analog_status;
            status_ff.rsvd7 <= 1'b0;
        end
    end

    // Read mux
    always_comb begin
        nxt_rdata = 8'h00;
        unique case (raddr)
            `SMR_IDX_SUPPLY:  nxt_rdata = supply_ff;
            `SMR_IDX_MONITOR: nxt_rdata = monitor_ff;
            `SMR_IDX_STATUS:  nxt_rdata = status_ff;
            `SMR_IDX_REVPART: nxt_rdata = {REVISION, PART_NUM};
            default:          nxt_rdata = 8'h00; // Unmapped
        endcase
    end

    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rresp_ff   <= `SMR_RESP_OKAY;
            rdata_ff   <= '0;
        end else if (ar_hs) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rdata_ff   <= nxt_rdata;
            rresp_ff   <= smr_mapped(raddr) ? `SMR_RESP_OKAY
                                            : `SMR_RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff  <= 1'b0;
        end else if (!rvalid_ff) begin
            arready_ff <= 1'b1;
        end
    end

    // Monitor include terms, one per masked rail
    assign mon_ok   = {status_ff.ldo20_rail, status_ff.conv2_rail,
                       status_ff.filter_rail};
    assign mon_mask = {monitor_ff.ldo20_monitor_mask,
                       monitor_ff.conv2_monitor_mask,
                       monitor_ff.filter_monitor_mask};
    for (genvar i = 0; i < NMON; i++) begin : g_mon
        assign mon_pass[i] = mon_ok[i] | mon_mask[i];
    end

    // Power section controls
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ldo20_on_ff <= 1'b0;
            conv2_on_ff <= 1'b0;
            trim_ff     <= '0;
        end else begin
            ldo20_on_ff <= supply_ff.ldo20_enable;
            conv2_on_ff <= supply_ff.conv2_enable;
            trim_ff     <= supply_ff.ldo20_current_trim;
        end
    end

    // Clock output gate and trigger pin
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_out_ff <= 1'b0;
            trig_o_ff  <= 1'b0;
            trig_oe_ff <= 1'b0;
        end else begin
            clk_out_ff <= supply_ff.clock_out_enable & clock_src;
            trig_oe_ff <= supply_ff.tx_monitor_enable;
            trig_o_ff  <= supply_ff.tx_monitor_enable &
                          tx_activity;
        end
    end

    // Analog output select and power-fail warning
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aout_sel_ff <= `SMR_AOUT_OFF;
            aout_on_ff  <= 1'b0;
            warn_n_ff   <= 1'b0;
        end else begin
            aout_sel_ff <= monitor_ff.analog_out_select;
            aout_on_ff  <= monitor_ff.analog_out_select !=
                           `SMR_AOUT_OFF;
            warn_n_ff   <= &mon_pass;
        end
    end

    // Output drive
    assign s_axi_awready        = awready_ff;
    assign s_axi_wready         = wready_ff;
    assign s_axi_bvalid         = bvalid_ff;
    assign s_axi_bresp          = bresp_ff;
    assign s_axi_arready        = arready_ff;
    assign s_axi_rvalid         = rvalid_ff;
    assign s_axi_rresp          = rresp_ff;
    assign s_axi_rdata          = {24'h000000, rdata_ff};
    assign ldo20_on             = ldo20_on_ff;
    assign conv2_on             = conv2_on_ff;
    assign clock_out_pin        = clk_out_ff;
    assign tx_monitor_pin_o     = trig_o_ff;
    assign tx_monitor_pin_oe    = trig_oe_ff;
    assign ldo20_current_trim   = trim_ff;
    assign analog_out_select    = aout_sel_ff;
    assign analog_out_on        = aout_on_ff;
    assign power_fail_warning_n = warn_n_ff;

    // Checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_ldo_follows: assert property (
        supply_ff.ldo20_enable != $past(supply_ff.ldo20_enable)
        |=> ldo20_on == $past(supply_ff.ldo20_enable))
        else $error("regulator enable not followed");
    a_conv2_off: assert property (
        (!supply_ff.conv2_enable) [*2] |-> !conv2_on)
        else $error("converter on while disabled");
    a_clock_gated: assert property (
        !supply_ff.clock_out_enable |=> !clock_out_pin)
        else $error("clock output runs while disabled");
    a_trig_mirror: assert property (
        supply_ff.tx_monitor_enable |=>
        tx_monitor_pin_oe && tx_monitor_pin_o == $past(tx_activity))
        else $error("trigger pin not mirroring activity");
    a_trig_release: assert property (
        !supply_ff.tx_monitor_enable |=> !tx_monitor_pin_oe)
        else $error("trigger pin driven while disabled");
    // Trim output is still at its reset value on the release edge
    a_trim_out: assert property (
        aresetn |=> ldo20_current_trim == $past(supply_ff.ldo20_current_trim))
        else $error("trim output mismatch");
    a_supply_write: assert property (
        wr_fire && wstrb_ff && waddr_ff == `SMR_IDX_SUPPLY
        |=> supply_ff == ($past(wdata_ff) & `SMR_SUPPLY_WMASK))
        else $error("supply write lost");
    a_mon_reserved: assert property (
        monitor_ff.rsvd0 == 1'b0 && monitor_ff.rsvd7 == 1'b0)
        else $error("monitor reserved bit set");

    a_warn_calc: assert property (
        ##1 power_fail_warning_n == $past(&mon_pass))
        else $error("power-fail warning mismatch");

    a_aout_on: assert property (
        ##1 analog_out_on ==
        ($past(monitor_ff.analog_out_select) != `SMR_AOUT_OFF))
        else $error("analog output enable mismatch");

    a_status_track: assert property (
        ##1 status_ff[6:0] == $past(analog_status[6:0]))
        else $error("status not tracking inputs");

    a_id_read: assert property (
        ar_hs && raddr == `SMR_IDX_REVPART |=>
        rvalid_ff && s_axi_rdata == {24'h000000, REVISION, PART_NUM})
        else $error("identity read wrong");

    a_rd_answer: assert property (
        ar_hs |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000)
        else $error("read answer late or upper bits set");

    a_wr_answer: assert property (
        wr_fire |=> s_axi_bvalid)
        else $error("write answer late");

    c_supply_wr: cover property (
        wr_fire && waddr_ff == `SMR_IDX_SUPPLY);
    c_status_rd: cover property (ar_hs && raddr == `SMR_IDX_STATUS);
    c_unmapped: cover property (ar_hs && !smr_mapped(raddr));
    c_warn_drop: cover property ($fell(power_fail_warning_n));

endmodule : smr_top

// *** testbench/smr_host_model.sv ***
`timescale 1ns/1ps
// Host side of the register bus: one write and one read at a time
module smr_host_model
#(
    parameter int ADDR_W = 8 // Register bus address width
) (
    input  logic              aclk,
    output logic [ADDR_W-1:0] s_axi_awaddr,
    output logic              s_axi_awvalid,
    input  logic              s_axi_awready,
    output logic [31:0]       s_axi_wdata,
    output logic [3:0]        s_axi_wstrb,
    output logic              s_axi_wvalid,
    input  logic              s_axi_wready,
    input  logic [1:0]        s_axi_bresp,
    input  logic              s_axi_bvalid,
    output logic              s_axi_bready,
    output logic [ADDR_W-1:0] s_axi_araddr,
    output logic              s_axi_arvalid,
    input  logic              s_axi_arready,
    input  logic [31:0]       s_axi_rdata,
    input  logic [1:0]        s_axi_rresp,
    input  logic              s_axi_rvalid,
    output logic              s_axi_rready
);
    // Idle bus at time zero
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
    end

    // Write: address and data offered together, each released when taken
    task automatic axi_write(input logic [ADDR_W-1:0] addr,
                             input logic [7:0] data,
                             input logic [3:0] strb,
                             output logic [1:0] resp);
        @(posedge aclk);
        s_axi_awaddr  <= addr;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= {24'h000000, data};
        s_axi_wstrb   <= strb;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            // Released lines show the inverse, never the stale value
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr  <= ~addr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata  <= ~s_axi_wdata;
            end
        end while (!(s_axi_bvalid && s_axi_bready));
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_write

    // Read: address held until taken, data taken at the rvalid edge
    task automatic axi_read(input logic [ADDR_W-1:0] addr,
                            output logic [31:0] data,
                            output logic [1:0] resp);
        @(posedge aclk);
        s_axi_araddr  <= addr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr  <= ~addr;
            end
        end while (!(s_axi_rvalid && s_axi_rready));
        data = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_read
endmodule : smr_host_model

// *** testbench/supply_monitor_regs_tb_top.sv ***
`timescale 1ns/1ps
`include "smr_regs.svh"
module supply_monitor_regs_tb_top
    import smr_pkg::*;
;
    localparam int         ADDR_W    = 8;
    localparam logic [2:0] REV_VAL   = 3'h3;  // Arbitrary value
    localparam logic [4:0] PART_VAL  = 5'h0a; // Arbitrary value
    localparam int         CYC_LIMIT = 20000; // Hang ceiling
    localparam logic [1:0] OK = `SMR_RESP_OKAY;
    localparam logic [1:0] ER = `SMR_RESP_SLVERR;

    logic              aclk = 1'b0;
    logic              aresetn;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic              awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready;
    logic [31:0]       wdata, rdata;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp;
    smr_status_t       analog_status;
    logic              tx_activity, clock_src;
    logic              ldo20_on, conv2_on, clock_out_pin;
    logic              tx_o, tx_oe, aout_on, warn_n;
    logic [2:0]        trim, aout_sel;
    int                error_cnt = 0;
    int                checks    = 0;
    int                cyc       = 0;
    logic [7:0]        rail_bit [3] = '{8'h08, 8'h20, 8'h40};

    // 200 MHz clock
    always #2.5 aclk = ~aclk;

    smr_host_model #(.ADDR_W(ADDR_W)) host_u (
        .aclk(aclk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    smr_top #(.ADDR_W(ADDR_W), .REVISION(REV_VAL), .PART_NUM(PART_VAL)) dut_u (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .analog_status(analog_status),
        .tx_activity(tx_activity), .clock_src(clock_src),
        .ldo20_on(ldo20_on), .conv2_on(conv2_on),
        .clock_out_pin(clock_out_pin), .tx_monitor_pin_o(tx_o),
        .tx_monitor_pin_oe(tx_oe), .ldo20_current_trim(trim),
        .analog_out_select(aout_sel), .analog_out_on(aout_on),
        .power_fail_warning_n(warn_n));

    // Compare a data or pin value
    task automatic chk_val(input string name, input logic [31:0] exp,
                           input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_val

    // Compare a bus response code
    task automatic chk_resp(input string name, input logic [1:0] exp,
                            input logic [1:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_resp

    // Register write by index with expected response
    task automatic wr(input logic [5:0] idx, input logic [7:0] data,
                      input logic [3:0] strb, input logic [1:0] exp);
        logic [1:0] resp;
        host_u.axi_write({idx, 2'b00}, data, strb, resp);
        chk_resp($sformatf("bresp idx %0d", idx), exp, resp);
    endtask : wr

    // Register read by index with expected data and response
    task automatic rd(input logic [5:0] idx, input logic [7:0] exp,
                      input logic [1:0] exp_resp);
        logic [31:0] data;
        logic [1:0]  resp;
        host_u.axi_read({idx, 2'b00}, data, resp);
        chk_resp($sformatf("rresp idx %0d", idx), exp_resp, resp);
        chk_val($sformatf("rdata idx %0d", idx), {24'h0, exp}, data);
    endtask : rd

    // Let registered pin outputs follow status and register changes
    task automatic settle();
        repeat (3) @(posedge aclk);
    endtask : settle

    // Closing report
    task automatic give_verdict();
        $display("Counts: %0d checks, %0d errors", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict

    // Hang guard
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == CYC_LIMIT) begin
            error_cnt++;
            give_verdict();
        end
    end

    // Main sequence
    initial begin
        aresetn = 1'b0;
        analog_status = smr_status_t'(8'h00);
        tx_activity = 1'b0;
        clock_src = 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        // Reset contents and pins
        rd(6'h01, 8'h74, OK);
        rd(6'h02, 8'h60, OK);
        rd(6'h03, 8'h00, OK);
        chk_val("trim", 32'(3'h4), 32'(trim));
        chk_val("tx_oe", 32'h0, 32'(tx_oe));
        rd(6'h05, {REV_VAL, PART_VAL}, OK);
        // Reserved bit and all enables
        clock_src <= 1'b1;
        tx_activity <= 1'b1;
        wr(6'h01, 8'hff, 4'h1, OK);
        rd(6'h01, 8'h7f, OK);
        settle();
        chk_val("tx_o", 32'h1, 32'(tx_o));
        tx_activity <= 1'b0;
        settle();
        chk_val("tx_o idle", 32'h0, 32'(tx_o));
        // One enable at a time, clock source held high
        for (int k = 0; k < 5; k++) begin
            wr(6'h01, 8'h08 << k, 4'h1, OK);
            settle();
            chk_val("ldo20_on", 32'(k == 3), 32'(ldo20_on));
            chk_val("conv2_on", 32'(k == 2), 32'(conv2_on));
            chk_val("clock_out", 32'(k == 1), 32'(clock_out_pin));
            chk_val("tx_oe", 32'(k == 0), 32'(tx_oe));
        end
        // Enabled clock output follows its source low
        wr(6'h01, 8'h10, 4'h1, OK);
        clock_src <= 1'b0;
        settle();
        chk_val("clock_out src low", 32'h0, 32'(clock_out_pin));
        // Every trim code
        for (int t = 0; t < 8; t++) begin
            wr(6'h01, 8'(t), 4'h1, OK);
            settle();
            chk_val("trim", 32'(t), 32'(trim));
        end
        wr(6'h01, 8'h55, 4'h0, OK);
        rd(6'h01, 8'h07, OK);
        // Monitor reserved bits and every select code
        wr(6'h02, 8'hff, 4'h1, OK);
        rd(6'h02, 8'h7e, OK);
        for (int c = 0; c < 8; c++) begin
            wr(6'h02, 8'(c << 1), 4'h1, OK);
            settle();
            chk_val("aout_sel", 32'(c), 32'(aout_sel));
            chk_val("aout_on", 32'(c != 0), 32'(aout_on));
        end
        // Each mask against each failing rail
        for (int m = 0; m < 8; m++) begin
            wr(6'h02, 8'(m << 4), 4'h1, OK);
            analog_status <= smr_status_t'(8'h7f);
            settle();
            chk_val("warn_n good", 32'h1, 32'(warn_n));
            for (int r = 0; r < 3; r++) begin
                analog_status <= smr_status_t'(8'h7f & ~rail_bit[r]);
                settle();
                chk_val("warn_n", 32'((m >> r) & 1), 32'(warn_n));
            end
        end
        // Walking one over the status word
        for (int i = 0; i < 8; i++) begin
            analog_status <= smr_status_t'(8'h01 << i);
            settle();
            rd(6'h03, (8'h01 << i) & 8'h7f, OK);
        end
        // Read-only writes and unmapped places
        wr(6'h03, 8'hff, 4'h1, OK);
        rd(6'h03, 8'h00, OK);
        wr(6'h05, 8'h00, 4'h1, OK);
        rd(6'h05, {REV_VAL, PART_VAL}, OK);
        wr(6'h00, 8'h11, 4'h1, ER);
        rd(6'h04, 8'h00, ER);
        rd(6'h07, 8'h00, ER);
        give_verdict();
    end
endmodule : supply_monitor_regs_tb_top
